// ==== src/aprh_pkg.sv ====
// Constants of the position readout block.
package aprh_pkg;

  // --------
  // Register map (byte addresses, one 32-bit word each)
  // --------
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFS_CMD         = 8'h00;
  localparam logic [7:0]  OFS_CTRL        = 8'h04;
  localparam logic [7:0]  OFS_STATUS      = 8'h08;
  localparam logic [7:0]  OFS_ABS_POS     = 8'h0C;
  localparam logic [7:0]  OFS_ABS_STS     = 8'h10;
  localparam logic [7:0]  OFS_POS_CMD     = 8'h14;
  localparam logic [7:0]  OFS_FB_POS      = 8'h18;
  localparam logic [7:0]  OFS_ENC_CNT     = 8'h1C;
  localparam logic [7:0]  OFS_MAX_POS     = 8'h20;
  localparam logic [7:0]  OFS_UPPER_LIM   = 8'h24;
  localparam logic [7:0]  OFS_LOWER_LIM   = 8'h28;
  localparam logic [7:0]  OFS_DEVIATION   = 8'h2C;

  // --------
  // Field positions
  // --------
  localparam int CMD_READ         = 0;
  localparam int CMD_READ_LOAD    = 1;
  localparam int CMD_HOME_PRESET  = 2;
  localparam int CMD_POST_ALARM   = 3;
  localparam int CMD_FAULT_CLEAR  = 4;
  localparam int CTRL_ENERGISED   = 0;
  localparam int CTRL_HOME_CLEAR  = 1;
  localparam int CTRL_SOFT_LIMIT  = 2;
  localparam int CTRL_REMOTE_MAP  = 3;
  localparam int CTRL_W           = 4;
  localparam int ST_BUSY          = 0;
  localparam int ST_DATA_READY    = 1;
  localparam int ST_LOAD_ERROR    = 2;
  localparam int ST_HOME_SET      = 3;
  localparam int ST_LIMITS_ON     = 4;

  // --------
  // Reset values
  // --------
  localparam logic [3:0]  CTRL_RST        = 4'h0;
  localparam logic [31:0] MAX_POS_RST     = 32'h7FFFFFFF;
  localparam logic [31:0] UPPER_LIM_RST   = 32'h7FFFFFFF;
  localparam logic [31:0] LOWER_LIM_RST   = 32'h80000001;

  // --------
  // Driver frame layout
  // --------
  localparam int FRAME_BITS       = 48;
  localparam int BITS_PER_STROBE  = 2;
  localparam int STROBE_COUNT     = FRAME_BITS / BITS_PER_STROBE;
  localparam int POS_MSB          = 47;
  localparam int POS_LSB          = 16;
  localparam int STS_MSB          = 15;
  localparam int STS_LSB          = 8;

  // --------
  // Timing
  // --------
  localparam int CLK_PERIOD_NS    = 100;
  localparam int PERMIT_TIME_NS   = 1000000;
  localparam int PERMIT_CYCLES    = PERMIT_TIME_NS / CLK_PERIOD_NS;
  localparam int PRESET_TIME_NS   = 1000000;
  localparam int PRESET_CYCLES    = PRESET_TIME_NS / CLK_PERIOD_NS;
  localparam int DCLR_TIME_NS     = 1000000;
  localparam int DCLR_CYCLES      = DCLR_TIME_NS / CLK_PERIOD_NS;
  localparam int STROBE_HALF_NS   = 5000;
  localparam int STROBE_HALF_CYC  = (STROBE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ==== src/aprh_pulse_timer.sv ====
// Retriggerable fixed-length output pulse used for the driver control lines.
`timescale 1ns/1ps
module aprh_pulse_timer #(
  parameter int LEN = 10000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Control
  input  wire logic start,
  output logic      pulse_ff
);

  localparam int CW = $clog2(LEN + 1);

  logic [CW-1:0] cnt_ff;

  // A start while running restarts the full length, so a repeat command is never cut short.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff   <= '0;
      pulse_ff <= 1'b0;
    end else if (start) begin
      cnt_ff   <= CW'(LEN - 1);
      pulse_ff <= 1'b1;
    end else if (cnt_ff != '0) begin
      cnt_ff   <= cnt_ff - 1'b1;
    end else begin
      pulse_ff <= 1'b0;
    end
  end

endmodule

// ==== src/aprh_abs_readout.sv ====
// Absolute position readout, position load, home preset and post-alarm recovery pulses.
// Operation
// (RULE_01) Read stores position and status/alarm codes.
// (RULE_02) Status word: status byte, then alarm byte.
// (RULE_03) Stored values hold until next read.
// (RULE_04) Load sets command, shifts feedback and encoder.
// (RULE_05) De-energised: command tracks feedback exactly.
// (RULE_06) Read always accepted; load refused while pulsing.
// (RULE_07) Position is signed milli-unit 32-bit value.
// (RULE_08) Loaded positions clamped to maximum position.
// (RULE_09) Data-ready output rises when data available.
// (RULE_10) Data-ready mappable onto remote output bit.
// (RULE_11) Home preset clears position command to zero.
// (RULE_12) Preset: feedback and encoder keep deviation.
// (RULE_13) Home preset also pulses driver preset output.
// (RULE_14) Post-alarm permit output pulses about 1 ms.
// (RULE_15) Home seek completion pulses preset output.
// (RULE_16) Home clear enabled: pulse deviation clear.
// (RULE_17) Host recovers: read, clear, permit, home seek.
// (RULE_18) Host de-energises motor around read-and-load.
// (RULE_19) Link: request, strobe out; ready, two bits in.
// (RULE_20) Soft-limit set: load sets home, enables limits.
// (RULE_21) Two bits per strobe after ready, then ready.
`timescale 1ns/1ps
module aprh_abs_readout #(
  parameter int PERMIT_CYCLES = aprh_pkg::PERMIT_CYCLES,
  parameter int PRESET_CYCLES = aprh_pkg::PRESET_CYCLES,
  parameter int DCLR_CYCLES   = aprh_pkg::DCLR_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Motion engine
  input  wire logic        pulse_active,
  input  wire logic        home_seek_done,
  output logic [31:0]      position_command,
  // Driver link
  output logic             read_req_out,
  output logic             xfer_strobe_out,
  input  wire logic        xfer_ready_in,
  input  wire logic        data_bit_zero_in,
  input  wire logic        data_bit_one_in,
  output logic             preset_out,
  output logic             post_alarm_permit_out,
  output logic             deviation_clear_out,
  // Status
  output logic             abs_data_ready_out,
  output logic             remote_ready_bit_out
);

  typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_STB_HI, ST_STB_LO, ST_DONE} aprh_state_t;

  localparam int DIV_W = $clog2(aprh_pkg::STROBE_HALF_CYC + 1);
  localparam int CNT_W = $clog2(aprh_pkg::STROBE_COUNT + 1);

  aprh_state_t                 state_ff;
  aprh_state_t                 nxt_state;
  logic [2:0]                  sync1_ff;
  logic [2:0]                  sync2_ff;
  logic [DIV_W-1:0]            div_ff;
  logic                        tick;
  logic [CNT_W-1:0]            bit_cnt_ff;
  logic [47:0]                 shift_ff;
  logic                        load_pending_ff;
  logic [31:0]                 abs_pos_ff;
  logic [15:0]                 abs_sts_ff;
  logic                        data_ready_ff;
  logic                        load_error_ff;
  logic                        home_set_ff;
  logic                        limits_on_ff;
  logic [aprh_pkg::CTRL_W-1:0] ctrl_ff;
  logic signed [31:0]          pc_ff;
  logic signed [31:0]          pf_ff;
  logic signed [31:0]          ec_ff;
  logic signed [31:0]          max_pos_ff;
  logic [31:0]                 upper_lim_ff;
  logic [31:0]                 lower_lim_ff;
  logic signed [31:0]          nxt_pc;
  logic signed [31:0]          nxt_pf;
  logic signed [31:0]          nxt_ec;
  logic signed [31:0]          load_val;
  logic signed [31:0]          delta;
  logic                        cmd_wr;
  logic                        read_go;
  logic                        load_req;
  logic                        load_go;
  logic                        preset_go;
  logic                        apply_load;
  logic                        finish;
  logic [31:0]                 rdata_ff;

  // Clamp a position to the configured symmetric maximum.
  function automatic logic signed [31:0] clamp_pos(input logic signed [31:0] val,
                                                   input logic signed [31:0] lim);
    logic signed [31:0] res;
    res = val;
    if (val > lim) begin
      res = lim;
    end else if (val < -lim) begin
      res = -lim;
    end
    return res;
  endfunction

  // --------
  // Command decode
  // --------
  // A load during pulse output would fight the motion engine, so it is refused and flagged.
  assign cmd_wr    = reg_wr && (reg_addr == aprh_pkg::OFS_CMD);
  assign load_req  = cmd_wr && reg_wdata[aprh_pkg::CMD_READ_LOAD];
  assign load_go   = load_req && !pulse_active; // RULE_06
  assign read_go   = cmd_wr && reg_wdata[aprh_pkg::CMD_READ]; // RULE_06
  assign preset_go = cmd_wr && reg_wdata[aprh_pkg::CMD_HOME_PRESET];
  assign finish     = (state_ff == ST_DONE);
  assign apply_load = finish && load_pending_ff;

  // --------
  // Driver input synchroniser
  // --------
  // Ready and both data bits come from the driver and pass two flip-flops first.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else begin
      sync1_ff <= {xfer_ready_in, data_bit_one_in, data_bit_zero_in};
      sync2_ff <= sync1_ff;
    end
  end

  // --------
  // Strobe rate divider
  // --------
  // The divider restarts on every idle period so each frame begins with a full half period.
  assign tick = (div_ff == DIV_W'(aprh_pkg::STROBE_HALF_CYC - 1));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff <= '0;
    end else if (state_ff == ST_IDLE || tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  // --------
  // Transfer sequencer
  // --------
  // No timeout on ready: a missing driver leaves the block busy until reset.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (read_go || load_go) begin
          nxt_state = ST_REQ;
        end
      end
      ST_REQ: begin
        if (tick && sync2_ff[2]) begin
          nxt_state = ST_STB_HI; // RULE_21
        end
      end
      ST_STB_HI: begin
        if (tick) begin
          nxt_state = ST_STB_LO;
        end
      end
      ST_STB_LO: begin
        if (tick) begin
          nxt_state = (bit_cnt_ff == CNT_W'(aprh_pkg::STROBE_COUNT)) ? ST_DONE : ST_STB_HI;
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // State and the two link outputs, registered from the next state.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff        <= ST_IDLE;
      read_req_out    <= 1'b0;
      xfer_strobe_out <= 1'b0;
    end else begin
      state_ff        <= nxt_state;
      read_req_out    <= (nxt_state == ST_REQ) || (nxt_state == ST_STB_HI) || (nxt_state == ST_STB_LO); // RULE_19
      xfer_strobe_out <= (nxt_state == ST_STB_HI); // RULE_19
    end
  end

  // Bits are sampled at the end of each strobe high phase, upper bit first.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_ff        <= 48'h0;
      bit_cnt_ff      <= '0;
      load_pending_ff <= 1'b0;
    end else if (state_ff == ST_IDLE) begin
      bit_cnt_ff <= '0;
      if (read_go || load_go) begin
        load_pending_ff <= load_go;
      end
    end else if (state_ff == ST_STB_HI && tick) begin
      shift_ff   <= {shift_ff[45:0], sync2_ff[1], sync2_ff[0]}; // RULE_21
      bit_cnt_ff <= bit_cnt_ff + 1'b1;
    end
  end

  // --------
  // Stored readout and flags
  // --------
  // The driver reports in thousandths of a user unit, so 32 signed bits span the full range.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      abs_pos_ff <= 32'h0;
      abs_sts_ff <= 16'h0;
    end else if (finish) begin
      abs_pos_ff <= shift_ff[aprh_pkg::POS_MSB:aprh_pkg::POS_LSB]; // RULE_01 RULE_07 RULE_03
      abs_sts_ff <= shift_ff[aprh_pkg::STS_MSB:0]; // RULE_02
    end
  end

  // Ready drops when a new read starts and rises with the stored data.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_ready_ff <= 1'b0;
    end else if (finish) begin
      data_ready_ff <= 1'b1; // RULE_09
    end else if (state_ff == ST_IDLE && (read_go || load_go)) begin
      data_ready_ff <= 1'b0;
    end
  end

  // A refused load sets the error; the fault clear command drops it, but a new refusal wins.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      load_error_ff <= 1'b0;
    end else if (load_req && pulse_active) begin
      load_error_ff <= 1'b1; // RULE_06
    end else if (cmd_wr && reg_wdata[aprh_pkg::CMD_FAULT_CLEAR]) begin
      load_error_ff <= 1'b0;
    end
  end

  // Home state set by a home preset or a soft-limit load; soft-limit state set only by a soft-limit load.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      home_set_ff  <= 1'b0;
      limits_on_ff <= 1'b0;
    end else if (preset_go) begin
      home_set_ff <= 1'b1;
    end else if (apply_load && ctrl_ff[aprh_pkg::CTRL_SOFT_LIMIT]) begin
      home_set_ff  <= 1'b1; // RULE_20
      limits_on_ff <= 1'b1; // RULE_20
    end
  end

  // --------
  // Configuration registers
  // --------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff      <= aprh_pkg::CTRL_RST;
      max_pos_ff   <= aprh_pkg::MAX_POS_RST;
      upper_lim_ff <= aprh_pkg::UPPER_LIM_RST;
      lower_lim_ff <= aprh_pkg::LOWER_LIM_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        aprh_pkg::OFS_CTRL:      ctrl_ff      <= reg_wdata[aprh_pkg::CTRL_W-1:0];
        aprh_pkg::OFS_MAX_POS:   max_pos_ff   <= reg_wdata;
        aprh_pkg::OFS_UPPER_LIM: upper_lim_ff <= reg_wdata;
        aprh_pkg::OFS_LOWER_LIM: lower_lim_ff <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // --------
  // Position registers
  // --------
  // Load and preset move feedback and encoder by the same step as the command, keeping deviation unless a load clamps feedback to the maximum.
  always_comb begin
    load_val = clamp_pos(abs_pos_ff, max_pos_ff);
    delta    = 32'sh0;
    nxt_pc   = pc_ff;
    nxt_pf   = pf_ff;
    nxt_ec   = ec_ff;
    if (reg_wr && reg_addr == aprh_pkg::OFS_POS_CMD) begin
      nxt_pc = reg_wdata;
    end
    if (reg_wr && reg_addr == aprh_pkg::OFS_FB_POS) begin
      nxt_pf = reg_wdata;
    end
    if (reg_wr && reg_addr == aprh_pkg::OFS_ENC_CNT) begin
      nxt_ec = reg_wdata;
    end
    if (apply_load) begin
      load_val = clamp_pos(shift_ff[aprh_pkg::POS_MSB:aprh_pkg::POS_LSB], max_pos_ff); // RULE_08
      delta    = load_val - pc_ff;
      nxt_pc   = load_val; // RULE_04
      nxt_pf   = clamp_pos(pf_ff + delta, max_pos_ff); // RULE_04 RULE_08
      nxt_ec   = ec_ff + delta; // RULE_04
    end else if (preset_go) begin
      nxt_pc = 32'sh0; // RULE_11
      nxt_pf = pf_ff - pc_ff; // RULE_12
      nxt_ec = ec_ff - pc_ff; // RULE_12
    end
    if (!ctrl_ff[aprh_pkg::CTRL_ENERGISED]) begin
      nxt_pc = nxt_pf; // RULE_05
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_ff <= 32'sh0;
      pf_ff <= 32'sh0;
      ec_ff <= 32'sh0;
    end else begin
      pc_ff <= nxt_pc;
      pf_ff <= nxt_pf;
      ec_ff <= nxt_ec;
    end
  end

  assign position_command = pc_ff;

  // --------
  // Driver control pulses
  // --------
  aprh_pulse_timer #(.LEN(PRESET_CYCLES)) u_preset (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .start    (preset_go || home_seek_done), // RULE_13 RULE_15
    .pulse_ff (preset_out)
  );

  aprh_pulse_timer #(.LEN(PERMIT_CYCLES)) u_permit (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .start    (cmd_wr && reg_wdata[aprh_pkg::CMD_POST_ALARM]), // RULE_14
    .pulse_ff (post_alarm_permit_out)
  );

  aprh_pulse_timer #(.LEN(DCLR_CYCLES)) u_devclr (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .start    (home_seek_done && ctrl_ff[aprh_pkg::CTRL_HOME_CLEAR]), // RULE_16
    .pulse_ff (deviation_clear_out)
  );

  // --------
  // Status outputs and read port
  // --------
  assign abs_data_ready_out   = data_ready_ff; // RULE_09
  assign remote_ready_bit_out = data_ready_ff && ctrl_ff[aprh_pkg::CTRL_REMOTE_MAP]; // RULE_10

  // Read data stand for the single cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        aprh_pkg::OFS_CTRL:      rdata_ff <= {28'h0, ctrl_ff};
        aprh_pkg::OFS_STATUS:    rdata_ff <= {27'h0, limits_on_ff, home_set_ff, load_error_ff,
                                              data_ready_ff, (state_ff != ST_IDLE)};
        aprh_pkg::OFS_ABS_POS:   rdata_ff <= abs_pos_ff; // RULE_03
        aprh_pkg::OFS_ABS_STS:   rdata_ff <= {16'h0, abs_sts_ff}; // RULE_02
        aprh_pkg::OFS_POS_CMD:   rdata_ff <= pc_ff;
        aprh_pkg::OFS_FB_POS:    rdata_ff <= pf_ff;
        aprh_pkg::OFS_ENC_CNT:   rdata_ff <= ec_ff;
        aprh_pkg::OFS_MAX_POS:   rdata_ff <= max_pos_ff;
        aprh_pkg::OFS_UPPER_LIM: rdata_ff <= upper_lim_ff;
        aprh_pkg::OFS_LOWER_LIM: rdata_ff <= lower_lim_ff;
        aprh_pkg::OFS_DEVIATION: rdata_ff <= pf_ff - pc_ff;
        default:                 rdata_ff <= 32'h0;
      endcase
    end else begin
      rdata_ff <= 32'h0;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule

// ==== tb/aprh_driver_model.sv ====
// Behavioural motor driver answering a position request with a two-bit-per-strobe frame.
`timescale 1ns/1ps
module aprh_driver_model (
  // Clock
  input  wire logic        clk,
  // Frame contents and answer delay set by the bench
  input  wire logic [47:0] frame,
  input  wire logic [7:0]  dly,
  // Link from the controller
  input  wire logic        read_req_out,
  input  wire logic        xfer_strobe_out,
  // Link to the controller
  output logic             xfer_ready_in,
  output logic             data_bit_zero_in,
  output logic             data_bit_one_in
);
  logic [7:0] wait_ff;
  logic [4:0] idx_ff;
  logic       stb_ff;

  // Known start levels, so the idle toggling below never stays unknown.
  initial begin
    wait_ff = 8'h00;
    xfer_ready_in = 1'b0;
    data_bit_zero_in = 1'b0;
    data_bit_one_in = 1'b1;
  end

  // Ready rises dly cycles after the request and falls with it, so both prompt and slow drivers are seen.
  always @(posedge clk) begin
    wait_ff <= !read_req_out ? 8'h00 : (wait_ff == dly) ? wait_ff : wait_ff + 8'h01;
    xfer_ready_in <= read_req_out && (wait_ff == dly);
  end

  // A new bit pair on each strobe rise, upper bit on bit one; outside frames the lines toggle as stale data.
  always @(posedge clk) begin
    stb_ff <= xfer_strobe_out;
    if (!read_req_out) begin
      idx_ff <= 5'h00;
      data_bit_one_in <= ~data_bit_one_in;
      data_bit_zero_in <= ~data_bit_zero_in;
    end else if (xfer_strobe_out && !stb_ff) begin
      {data_bit_one_in, data_bit_zero_in} <= frame[47 - 2 * idx_ff -: 2];
      idx_ff <= idx_ff + 5'h01;
    end
  end
endmodule

// ==== tb/aprh_abs_readout_monitor.sv ====
// Concurrent checks on the ports of the absolute position readout block.
`timescale 1ns/1ps
module aprh_abs_readout_monitor #(
  parameter int PERMIT_CYCLES = aprh_pkg::PERMIT_CYCLES
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Motion engine, driver link and status
  input wire logic        home_seek_done,
  input wire logic [31:0] position_command,
  input wire logic        read_req_out,
  input wire logic        xfer_strobe_out,
  input wire logic        preset_out,
  input wire logic        post_alarm_permit_out,
  input wire logic        deviation_clear_out,
  input wire logic        abs_data_ready_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic [15:0] stb_cnt_ff;
  logic [15:0] prm_cnt_ff;
  logic        hclr_ff;

  // High-time counters; a repetition cannot hold counts this long.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stb_cnt_ff <= 16'h0000;
      prm_cnt_ff <= 16'h0000;
    end else begin
      stb_cnt_ff <= xfer_strobe_out ? stb_cnt_ff + 16'h0001 : 16'h0000;
      prm_cnt_ff <= post_alarm_permit_out ? prm_cnt_ff + 16'h0001 : 16'h0000;
    end
  end

  // Shadow of the home clear enable bit, which is not visible at the ports.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hclr_ff <= 1'b0;
    end else if (reg_wr && reg_addr == aprh_pkg::OFS_CTRL) begin
      hclr_ff <= reg_wdata[aprh_pkg::CTRL_HOME_CLEAR];
    end
  end

  sequence s_cmd(int b);
    reg_wr && reg_addr == aprh_pkg::OFS_CMD && reg_wdata[b];
  endsequence
  sequence s_frame_end;
    $fell(read_req_out);
  endsequence

  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read");
  property p_req_start; s_cmd(aprh_pkg::CMD_READ) ##0 !read_req_out |=> read_req_out; endproperty
  a_req_start: assert property (p_req_start) else $error("read request not raised");
  property p_ready_after; s_frame_end |=> abs_data_ready_out; endproperty
  a_ready_after: assert property (p_ready_after) else $error("data ready late");
  property p_ready_clear; $rose(read_req_out) |-> !abs_data_ready_out; endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("stale data ready");
  property p_strobe_width; $fell(xfer_strobe_out) |-> stb_cnt_ff == aprh_pkg::STROBE_HALF_CYC; endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");
  property p_permit_len; $fell(post_alarm_permit_out) |-> prm_cnt_ff == PERMIT_CYCLES; endproperty
  a_permit_len: assert property (p_permit_len) else $error("permit pulse length wrong");
  property p_seek_preset; home_seek_done |=> preset_out; endproperty
  a_seek_preset: assert property (p_seek_preset) else $error("no preset after home seek");
  property p_preset_cmd; s_cmd(aprh_pkg::CMD_HOME_PRESET) |=> preset_out && position_command == 32'h0; endproperty
  a_preset_cmd: assert property (p_preset_cmd) else $error("preset command not applied");
  property p_dclr; home_seek_done && hclr_ff |=> deviation_clear_out; endproperty
  a_dclr: assert property (p_dclr) else $error("deviation clear missing");
endmodule

bind aprh_abs_readout aprh_abs_readout_monitor #(.PERMIT_CYCLES(PERMIT_CYCLES)) u_aprh_abs_readout_monitor (
  .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .home_seek_done, .position_command,
  .read_req_out, .xfer_strobe_out, .preset_out, .post_alarm_permit_out, .deviation_clear_out, .abs_data_ready_out
);

// ==== tb/aprh_abs_readout_tb_top.sv ====
// Self-checking bench for the absolute position readout block.
`timescale 1ns/1ps
module aprh_abs_readout_tb_top;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, pulse_active = 1'b0, home_seek_done = 1'b0, rd_q = 1'b0;
  logic [31:0] reg_rdata, position_command, pos, seed = 32'h15476D18;
  logic        read_req_out, xfer_strobe_out, xfer_ready_in, data_bit_zero_in, data_bit_one_in;
  logic        preset_out, post_alarm_permit_out, deviation_clear_out, abs_data_ready_out, remote_ready_bit_out;
  logic [47:0] frame = 48'h0;
  logic [7:0]  dly = 8'h00;
  logic [31:0] exp_q[$];
  string       name_q[$];
  int          err_total = 0, total_checks = 0, n;

  aprh_abs_readout #(.PERMIT_CYCLES(8), .PRESET_CYCLES(8), .DCLR_CYCLES(8)) u_aprh_abs_readout (
    .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pulse_active, .home_seek_done,
    .position_command, .read_req_out, .xfer_strobe_out, .xfer_ready_in, .data_bit_zero_in, .data_bit_one_in,
    .preset_out, .post_alarm_permit_out, .deviation_clear_out, .abs_data_ready_out, .remote_ready_bit_out);
  aprh_driver_model u_drv (.clk, .frame, .dly, .read_req_out, .xfer_strobe_out, .xfer_ready_in,
    .data_bit_zero_in, .data_bit_one_in);

  // Free-running 10 MHz clock.
  always #50 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // A read notes its expectation; the watcher below compares when the data stand.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    name_q.push_back(nm);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // Bounded wait, since the driver may never answer.
  task automatic wait_rdy;
    int k;
    k = 0;
    repeat (3) @(posedge clk);
    while (abs_data_ready_out !== 1'b1 && k < 4000) begin
      @(posedge clk);
      k++;
    end
    chk("data ready", {31'h0, abs_data_ready_out}, 32'h1);
  endtask

  task automatic close_out;
    $display("Checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken exactly there.
  always @(posedge clk) begin
    if (rd_q) begin
      chk(name_q.pop_front(), reg_rdata, exp_q.pop_front());
    end
    rd_q <= reg_rd;
  end

  // Cut a hang short well after the expected run length.
  initial begin
    #(100 * 60000);
    err_total++;
    close_out();
  end

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h04, 32'h0, "ctrl reset");
    rd(8'h20, 32'h7FFFFFFF, "max reset");
    rd(8'h28, 32'h80000001, "lower reset");
    rd(8'h30, 32'h0, "unmapped");
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      pos = (i == 0) ? 32'h80000000 : seed;
      frame <= {pos, seed[15:0]};
      dly <= seed[23:16];
      wr(8'h00, 32'h1);
      wait_rdy();
      rd(8'h0C, pos, "abs pos");
      rd(8'h10, {16'h0, seed[15:0]}, "status word");
    end
    frame <= ~frame;
    wr(8'h04, 32'h8);
    @(posedge clk);
    chk("remote bit", {31'h0, remote_ready_bit_out}, 32'h1);
    rd(8'h0C, pos, "abs pos held");
    $display("read test done");
    wr(8'h04, 32'h1);
    wr(8'h14, 32'h100);
    wr(8'h18, 32'h180);
    wr(8'h1C, 32'h500);
    pos = {20'h0, seed[31:20]};
    frame <= {pos, 16'h1C48};
    wr(8'h00, 32'h2);
    wait_rdy();
    chk("cmd port", position_command, pos);
    rd(8'h18, pos + 32'h80, "feedback");
    rd(8'h1C, pos + 32'h400, "encoder");
    rd(8'h2C, 32'h80, "deviation");
    wr(8'h04, 32'h4);
    wr(8'h20, 32'h3E8);
    frame <= {2'b01, seed[29:0], 16'hFFFF};
    wr(8'h00, 32'h2);
    wait_rdy();
    rd(8'h08, 32'h1A, "limits on");
    wr(8'h04, 32'h1);
    rd(8'h14, 32'h3E8, "clamped cmd");
    rd(8'h18, 32'h3E8, "clamped feedback");
    $display("load test done");
    pulse_active <= 1'b1;
    wr(8'h00, 32'h2);
    rd(8'h08, 32'h1E, "load refused");
    chk("no request", {31'h0, read_req_out}, 32'h0);
    wr(8'h00, 32'h1);
    wait_rdy();
    pulse_active <= 1'b0;
    wr(8'h00, 32'h10);
    rd(8'h08, 32'h1A, "fault cleared");
    wr(8'h00, 32'h8);
    n = 0;
    repeat (20) begin
      #1;
      n += post_alarm_permit_out;
      @(posedge clk);
    end
    chk("permit width", n, 32'h8);
    wr(8'h04, 32'h3);
    home_seek_done <= 1'b1;
    @(posedge clk);
    home_seek_done <= 1'b0;
    @(posedge clk);
    #1;
    chk("seek pulses", {30'h0, preset_out, deviation_clear_out}, 32'h3);
    $display("recovery test done");
    wr(8'h14, 32'h200);
    wr(8'h18, 32'h260);
    wr(8'h1C, 32'h900);
    repeat (4) @(posedge clk);
    wr(8'h00, 32'h4);
    @(posedge clk);
    #1;
    chk("preset pulse", {31'h0, preset_out}, 32'h1);
    chk("cmd zero", position_command, 32'h0);
    rd(8'h18, 32'h60, "feedback preset");
    rd(8'h1C, 32'h700, "encoder preset");
    repeat (2) @(posedge clk);
    $display("preset test done");
    close_out();
  end
endmodule
